// ---- hdl/i2csp_if.sv ----
// Interface joining the slave port and the master end.
// Separate data-in and data-out wires; SCL driven by the master only.
`default_nettype none
interface i2csp_if;
    logic scl;
    logic sda_m;
    logic sda_m_oe;
    logic sda_s;
    logic sda_s_oe;
    logic sda_line;
    // Open-drain wired-AND with an implied pull-up
    assign sda_line = !((sda_m_oe && !sda_m) || (sda_s_oe && !sda_s));
    modport slave  (input scl, input sda_line, output sda_s, output sda_s_oe);
    modport master (output scl, output sda_m, output sda_m_oe, input sda_line);
endinterface : i2csp_if
`default_nettype wire

// ---- hdl/i2csp_master.sv ----
// Master end: one byte-level command at a time on the two-wire bus.
// Assumes user holds cmd fields stable while cmd_valid and not cmd_ready.
`default_nettype none
module i2csp_master (
    input  wire logic       clk,
    input  wire logic       rst,
    i2csp_if.master         bus,
    input  wire logic       cmd_valid,
    output logic            cmd_ready,
    input  wire logic       cmd_start,
    input  wire logic       cmd_stop,
    input  wire logic       cmd_read,
    input  wire logic       cmd_ack,
    input  wire logic [7:0] cmd_data,
    output logic            rsp_valid,
    output logic [7:0]      rsp_data,
    output logic            rsp_nack
);
    typedef enum logic [4:0] {
        I2CSPM_IDLE  = 5'b00001,
        I2CSPM_START = 5'b00010,
        I2CSPM_BIT   = 5'b00100,
        I2CSPM_STOP  = 5'b01000,
        I2CSPM_DONE  = 5'b10000
    } i2cspm_st_t;

    i2cspm_st_t st_q, st_d;
    logic [7:0] div_q, div_d;
    logic [1:0] ph_q, ph_d;
    logic [3:0] bit_q, bit_d;
    logic [8:0] sh_q, sh_d;
    logic [7:0] rx_q, rx_d;
    logic       scl_q, scl_d, sda_q, sda_d, nack_q, nack_d;
    logic       rd_q, rd_d, stp_q, stp_d, tick;

    // R02 SCL half period well above ten clocks
    assign tick = (div_q == i2csp_pkg::HALF_CNT);

    always_comb begin
        st_d   = st_q;
        div_d  = tick ? 8'h00 : div_q + 8'h01;
        ph_d   = ph_q;
        bit_d  = bit_q;
        sh_d   = sh_q;
        rx_d   = rx_q;
        scl_d  = scl_q;
        sda_d  = sda_q;
        nack_d = nack_q;
        rd_d   = rd_q;
        stp_d  = stp_q;
        case (st_q)
            I2CSPM_IDLE: begin
                div_d = 8'h00;
                if (cmd_valid) begin
                    rd_d  = cmd_read;
                    stp_d = cmd_stop;
                    // Read: release data bits, drive ack bit
                    sh_d  = cmd_read ? {8'hFF, !cmd_ack} : {cmd_data, 1'b1};
                    bit_d = 4'h0;
                    ph_d  = 2'h0;
                    st_d  = cmd_start ? I2CSPM_START : I2CSPM_BIT;
                end
            end
            I2CSPM_START: begin
                // R05 SDA falls with SCL high
                if (tick) begin
                    ph_d = ph_q + 2'h1;
                    case (ph_q)
                        2'h0: begin sda_d = 1'b1; end
                        2'h1: begin scl_d = 1'b1; end
                        2'h2: begin sda_d = 1'b0; end
                        default: begin
                            scl_d = 1'b0;
                            ph_d  = 2'h0;
                            st_d  = I2CSPM_BIT;
                        end
                    endcase
                end
            end
            I2CSPM_BIT: begin
                if (tick) begin
                    ph_d = ph_q + 2'h1;
                    case (ph_q)
                        // R04 change SDA only while SCL low
                        2'h0: begin sda_d = sh_q[8]; end
                        2'h1: begin scl_d = 1'b1; end
                        2'h2: begin
                            // R08 MSB first, sampled at SCL high
                            rx_d = (bit_q < 4'h8) ? {rx_q[6:0], bus.sda_line} : rx_q;
                            if (bit_q == 4'h8) begin
                                nack_d = bus.sda_line;
                            end
                        end
                        default: begin
                            scl_d = 1'b0;
                            ph_d  = 2'h0;
                            sh_d  = {sh_q[7:0], 1'b1};
                            bit_d = bit_q + 4'h1;
                            if (bit_q == 4'h8) begin
                                st_d = stp_q ? I2CSPM_STOP : I2CSPM_DONE;
                            end
                        end
                    endcase
                end
            end
            I2CSPM_STOP: begin
                // R06 SDA rises with SCL high
                if (tick) begin
                    ph_d = ph_q + 2'h1;
                    case (ph_q)
                        2'h0: begin sda_d = 1'b0; end
                        2'h1: begin scl_d = 1'b1; end
                        2'h2: begin sda_d = 1'b1; end
                        default: begin st_d = I2CSPM_DONE; end
                    endcase
                end
            end
            default: begin
                st_d = I2CSPM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q   <= I2CSPM_IDLE;
            div_q  <= 8'h00;
            ph_q   <= 2'h0;
            bit_q  <= 4'h0;
            sh_q   <= 9'h1FF;
            rx_q   <= 8'h00;
            scl_q  <= 1'b1;
            sda_q  <= 1'b1;
            nack_q <= 1'b0;
            rd_q   <= 1'b0;
            stp_q  <= 1'b0;
        end else begin
            st_q   <= st_d;
            div_q  <= div_d;
            ph_q   <= ph_d;
            bit_q  <= bit_d;
            sh_q   <= sh_d;
            rx_q   <= rx_d;
            scl_q  <= scl_d;
            sda_q  <= sda_d;
            nack_q <= nack_d;
            rd_q   <= rd_d;
            stp_q  <= stp_d;
        end
    end

    assign cmd_ready    = (st_q == I2CSPM_IDLE);
    assign rsp_valid    = (st_q == I2CSPM_DONE);
    assign rsp_data     = rx_q;
    assign rsp_nack     = nack_q;
    assign bus.scl      = scl_q;
    assign bus.sda_m    = sda_q;
    assign bus.sda_m_oe = !sda_q;
endmodule : i2csp_master
`default_nettype wire

// ---- hdl/i2csp_pkg.sv ----
// Package for the two-wire slave register port and its master end.
// Assumes both ends share one 40 MHz clock and an active-high async reset.
`default_nettype none
package i2csp_pkg;
    // Slave addresses picked by the address-select strap
    localparam logic [6:0] ADDR_STRAP_LO = 7'h38;
    localparam logic [6:0] ADDR_STRAP_HI = 7'h3A;
    // Direction bit values
    localparam logic       DIR_WRITE     = 1'h0;
    localparam logic       DIR_READ      = 1'h1;
    // Clock and bit rate
    localparam int         CLK_HZ        = 40000000;
    localparam int         SCL_HZ        = 400000;
    // Clocks per SCL half period; SCL must stay at or below clock / 10
    localparam int         HALF_CYC      = CLK_HZ / (2 * SCL_HZ);
    localparam logic [7:0] HALF_CNT      = 8'(HALF_CYC);
    localparam logic [7:0] MEM_RESET     = 8'h00;
    localparam logic [7:0] PTR_RESET     = 8'h00;
endpackage : i2csp_pkg
`default_nettype wire

// ---- hdl/i2csp_slave.sv ----
// Two-wire slave port with 256-byte configuration space.
// Assumes SCL at most a tenth of clk; bus inputs are asynchronous.
// Operation
// R01 - Slave only, up to 400 kbit/s
// R02 - Master keeps SCL below clock/10
// R03 - SDA in and out split, SCL input
// R04 - Master changes SDA only while SCL low
// R05 - START is SDA fall, SCL high
// R06 - STOP is SDA rise, ends transfer
// R07 - Sample SDA on rising SCL
// R08 - Select byte: address then direction, MSB first
// R09 - Address 0x38 or 0x3A by strap
// R10 - Direction 1 read, 0 write
// R11 - Acknowledge match on ninth bit
// R12 - Byte after select is register address
// R13 - Single byte write acknowledged and stored
// R14 - Multi-byte write until STOP
// R15 - Current-address read returns one byte
// R16 - Reads return consecutive addresses while acknowledged
// R17 - Random read via repeated START
// R18 - Pointer increments, kept between transfers
// R19 - No match: released, ignore until START
// R20 - Synchronise SCL and SDA before detection
`default_nettype none
module i2csp_slave (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic addr_select_pin,
    i2csp_if.slave    bus,
    output logic [7:0] last_addr,
    output logic       busy
);
    typedef enum logic [5:0] {
        I2CSP_IDLE = 6'b000001,
        I2CSP_SEL  = 6'b000010,
        I2CSP_REG  = 6'b000100,
        I2CSP_WDAT = 6'b001000,
        I2CSP_RDAT = 6'b010000,
        I2CSP_RACK = 6'b100000
    } i2csp_st_t;

    ////////////////////////////////////////////////////////////////////
    // R20 two-flop sync, then a history stage for edges
    logic [2:0] scl_q, sda_q;
    logic [1:0] strap_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_q   <= 3'h7;
            sda_q   <= 3'h7;
            strap_q <= 2'h0;
        end else begin
            scl_q   <= {scl_q[1:0], bus.scl};
            sda_q   <= {sda_q[1:0], bus.sda_line};
            strap_q <= {strap_q[0], addr_select_pin};
        end
    end
    logic scl_rise, scl_fall, start_det, stop_det;
    // R07 rising SCL edge
    assign scl_rise  = scl_q[1] && !scl_q[2];
    assign scl_fall  = !scl_q[1] && scl_q[2];
    // R05 START detect
    assign start_det = scl_q[1] && scl_q[2] && sda_q[2] && !sda_q[1];
    // R06 STOP detect
    assign stop_det  = scl_q[1] && scl_q[2] && !sda_q[2] && sda_q[1];

    ////////////////////////////////////////////////////////////////////
    i2csp_st_t  st_q, st_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d;
    logic [7:0] ptr_q, ptr_d;
    logic       ack_q, ack_d;
    logic       oe_q, oe_d;
    logic       sdo_q, sdo_d;
    logic [7:0] mem_q [256];
    logic       we;
    logic [6:0] my_addr;
    logic [7:0] rd_byte;

    // R09 strap-selected address
    assign my_addr = strap_q[1] ? i2csp_pkg::ADDR_STRAP_HI : i2csp_pkg::ADDR_STRAP_LO;
    assign rd_byte = mem_q[ptr_q];

    always_comb begin
        st_d  = st_q;
        bit_d = bit_q;
        sh_d  = sh_q;
        ptr_d = ptr_q;
        ack_d = ack_q;
        oe_d  = oe_q;
        sdo_d = sdo_q;
        we    = 1'b0;
        if (start_det) begin
            // R17 repeated START reopens selection
            st_d  = I2CSP_SEL;
            bit_d = 4'h0;
            oe_d  = 1'b0;
            ack_d = 1'b0;
        end else if (stop_det) begin
            // R06 STOP ends transfer
            st_d = I2CSP_IDLE;
            oe_d = 1'b0;
        end else if (st_q != I2CSP_IDLE) begin
            if (scl_rise) begin
                // R07 sample on rising SCL
                if (bit_q < 4'h8) begin
                    sh_d = {sh_q[6:0], sda_q[1]};
                end
                bit_d = bit_q + 4'h1;
                // R16 master ack decides continuation
                if (st_q == I2CSP_RACK && bit_q == 4'h8 && sda_q[1]) begin
                    st_d = I2CSP_IDLE;
                end
            end else if (scl_fall) begin
                if (bit_q == 4'h8) begin
                    ack_d = 1'b0;
                    oe_d  = 1'b0;
                    case (st_q)
                        I2CSP_SEL: begin
                            // R08 R19 address check
                            if (sh_q[7:1] == my_addr) begin
                                // R11 acknowledge on ninth bit
                                oe_d  = 1'b1;
                                sdo_d = 1'b0;
                                ack_d = 1'b1;
                                // R10 direction bit
                                st_d = (sh_q[0] == i2csp_pkg::DIR_READ) ? I2CSP_RDAT : I2CSP_REG;
                            end else begin
                                st_d = I2CSP_IDLE;
                            end
                        end
                        I2CSP_REG: begin
                            // R12 register address taken
                            ptr_d = sh_q;
                            oe_d  = 1'b1;
                            sdo_d = 1'b0;
                            st_d  = I2CSP_WDAT;
                        end
                        I2CSP_WDAT: begin
                            // R13 R14 store, acknowledge
                            we    = 1'b1;
                            oe_d  = 1'b1;
                            sdo_d = 1'b0;
                            ack_d = 1'b1;
                        end
                        default: begin
                            // RDAT bits done: release for master ack
                            st_d = I2CSP_RACK;
                        end
                    endcase
                end else if (bit_q == 4'h9) begin
                    bit_d = 4'h0;
                    oe_d  = 1'b0;
                    if (st_q == I2CSP_RDAT || st_q == I2CSP_RACK) begin
                        // R15 R16 shift out current byte
                        st_d  = I2CSP_RDAT;
                        oe_d  = 1'b1;
                        sdo_d = rd_byte[7];
                        sh_d  = rd_byte;
                        // R18 advance after read
                        ptr_d = ptr_q + 8'h01;
                    end
                    if (st_q == I2CSP_WDAT && ack_q == 1'b1) begin
                        // R18 advance after write
                        ptr_d = ptr_q + 8'h01;
                    end
                    ack_d = 1'b0;
                end else if (st_q == I2CSP_RDAT) begin
                    // Byte moves left on every rise, so the next bit is the MSB
                    sdo_d = sh_q[7];
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q  <= I2CSP_IDLE;
            bit_q <= 4'h0;
            sh_q  <= 8'h00;
            ptr_q <= i2csp_pkg::PTR_RESET;
            ack_q <= 1'b0;
            oe_q  <= 1'b0;
            sdo_q <= 1'b1;
        end else begin
            st_q  <= st_d;
            bit_q <= bit_d;
            sh_q  <= sh_d;
            ptr_q <= ptr_d;
            ack_q <= ack_d;
            oe_q  <= oe_d;
            sdo_q <= sdo_d;
        end
    end

    // Storage kept apart from the control state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 256; i++) begin
                mem_q[i] <= i2csp_pkg::MEM_RESET;
            end
        end else if (we) begin
            mem_q[ptr_q] <= sh_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // R01 slave only: SCL is never driven
    // R03 separate output pin, open-drain style
    assign bus.sda_s    = sdo_q;
    assign bus.sda_s_oe = oe_q;
    assign last_addr    = ptr_q;
    assign busy         = (st_q != I2CSP_IDLE);
endmodule : i2csp_slave
`default_nettype wire

// ---- sim/i2csp_properties.sv ----
// Concurrent checks on the two-wire link between the slave port and the master end.
// Assumes every link signal is launched from clk, so one sample per edge sees it all.
`default_nettype none
module i2csp_properties (
    input wire logic clk,
    input wire logic rst,
    input wire logic addr_select_pin,
    input wire logic scl,
    input wire logic sda_line,
    input wire logic sda_s,
    input wire logic sda_s_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       scl_q;
    logic       sda_q;
    logic       idle_q;
    logic       idle_d;
    logic [3:0] bit_q;
    logic [3:0] bit_d;
    logic [1:0] byte_q;
    logic [1:0] byte_d;
    logic [7:0] sel_q;
    logic [7:0] sel_d;
    logic [6:0] sh_q;
    logic [6:0] sh_d;
    logic       rise;
    logic       start_ev;
    logic       stop_ev;
    logic       match;
    logic       pull_s;

    ////////////////////////////////////////////////////////////////////////////////
    // Frame tracker: bit and byte position since the last START
    always_comb begin
        rise     = scl && !scl_q;
        start_ev = scl && scl_q && sda_q && !sda_line;
        stop_ev  = scl && scl_q && !sda_q && sda_line;
        pull_s   = sda_s_oe && !sda_s;
        match    = sel_q[7:1] == (addr_select_pin ? i2csp_pkg::ADDR_STRAP_HI
                                                  : i2csp_pkg::ADDR_STRAP_LO);
        idle_d = idle_q;
        bit_d  = bit_q;
        byte_d = byte_q;
        sel_d  = sel_q;
        sh_d   = sh_q;
        if (rise) begin
            sh_d  = {sh_q[5:0], sda_line};
            bit_d = (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
            if (bit_q == 4'h7 && byte_q == 2'h0) begin
                sel_d = {sh_q, sda_line};
            end
            // Saturates: only first byte versus later bytes matters
            if (bit_q == 4'h8 && byte_q != 2'h3) begin
                byte_d = byte_q + 2'h1;
            end
        end
        if (start_ev) begin
            bit_d  = 4'h0;
            byte_d = 2'h0;
            idle_d = 1'b0;
        end
        if (stop_ev) begin
            idle_d = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_q  <= 1'b1;
            sda_q  <= 1'b1;
            idle_q <= 1'b1;
            bit_q  <= 4'h0;
            byte_q <= 2'h0;
            sel_q  <= 8'h00;
            sh_q   <= 7'h00;
        end else begin
            scl_q  <= scl;
            sda_q  <= sda_line;
            idle_q <= idle_d;
            bit_q  <= bit_d;
            byte_q <= byte_d;
            sel_q  <= sel_d;
            sh_q   <= sh_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_SELECT_ACK: assert property (
        !idle_q && rise && bit_q == 4'h8 && byte_q == 2'h0 |-> sda_line == !match)
        else $error("select acknowledge disagrees with the address match");
    AST_WRITE_ACK: assert property (
        !idle_q && rise && bit_q == 4'h8 && byte_q != 2'h0 && match && !sel_q[0] |-> !sda_line)
        else $error("write byte not acknowledged");
    AST_READ_ACK_FREE: assert property (
        !idle_q && rise && bit_q == 4'h8 && byte_q != 2'h0 && sel_q[0] |-> !pull_s)
        else $error("slave drives the master acknowledge slot");
    AST_FOREIGN_QUIET: assert property (
        !idle_q && byte_q != 2'h0 && !match |-> !pull_s)
        else $error("slave drives after a foreign select byte");
    AST_IDLE_QUIET: assert property (
        idle_q |-> !pull_s)
        else $error("slave drives outside a frame");
    AST_SELECT_QUIET: assert property (
        !idle_q && byte_q == 2'h0 && bit_q != 4'h8 |-> !pull_s)
        else $error("slave drives during the select byte");
    AST_ACK_TIMELY: assert property (
        !idle_q && $fell(scl) && bit_q == 4'h8 && byte_q == 2'h0 && match |-> ##[1:6] pull_s)
        else $error("select acknowledge late");
    AST_ACK_STANDS: assert property (
        !idle_q && rise && !sda_line && bit_q == 4'h8 && byte_q == 2'h0 |-> (scl && pull_s)[*8])
        else $error("acknowledge dropped while clock high");
    AST_SYNC_DELAY: assert property (
        $fell(scl) |=> $stable(sda_s_oe) && $stable(sda_s))
        else $error("slave output reacts without synchroniser delay");
    AST_SCL_LOW_CHANGE: assert property (
        $changed(sda_s_oe) || (sda_s_oe && $changed(sda_s)) |-> !scl)
        else $error("slave output changes while clock high");
endmodule // i2csp_properties
`default_nettype wire

// ---- sim/tb_i2c_slave_register_port.sv ----
// Self-checking bench: master end drives the slave port over the shared link.
// Assumes one 40 MHz clock; expected bytes come from a 256-entry model array.
`default_nettype none
module tb_i2c_slave_register_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk;
    logic       rst;
    logic       addr_select_pin;
    logic       cmd_valid;
    logic       cmd_ready;
    logic       cmd_start;
    logic       cmd_stop;
    logic       cmd_read;
    logic       cmd_ack;
    logic [7:0] cmd_data;
    logic       rsp_valid;
    logic [7:0] rsp_data;
    logic       rsp_nack;
    logic [7:0] last_addr;
    logic       busy;
    logic [7:0] mem_m [256];
    logic [7:0] ptr_m;
    logic [7:0] got;
    logic       nack;
    int         n_fail;
    int         samples_checked;
    int         seed;

    i2csp_if bus_if ();
    i2csp_slave u_i2csp_slave (.clk(clk), .rst(rst), .addr_select_pin(addr_select_pin),
        .bus(bus_if), .last_addr(last_addr), .busy(busy));
    i2csp_master u_i2csp_master (.clk(clk), .rst(rst), .bus(bus_if), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_start(cmd_start), .cmd_stop(cmd_stop), .cmd_read(cmd_read),
        .cmd_ack(cmd_ack), .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_nack(rsp_nack));
    i2csp_properties chk (.clk(clk), .rst(rst), .addr_select_pin(addr_select_pin),
        .scl(bus_if.scl), .sda_line(bus_if.sda_line), .sda_s(bus_if.sda_s),
        .sda_s_oe(bus_if.sda_s_oe));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [6:0] own_addr();
        return addr_select_pin ? i2csp_pkg::ADDR_STRAP_HI : i2csp_pkg::ADDR_STRAP_LO;
    endfunction

    // One byte on the link; fields held until the edge that takes them
    task automatic xfer(input logic st, input logic sp, input logic rd, input logic ak,
                        input logic [7:0] d);
        int n;
        n = 0;
        {cmd_start, cmd_stop, cmd_read, cmd_ack, cmd_data} = {st, sp, rd, ak, d};
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1 && n < 8000) begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 8000) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("response", {7'h00, rsp_valid}, 8'h01);
        got  = rsp_data;
        nack = rsp_nack;
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (!(cmd_ready === 1'b1 && busy === 1'b0) && n < 8000) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    task automatic wr(input logic [7:0] reg_a, input int len);
        logic [7:0] d;
        xfer(1'b1, 1'b0, 1'b0, 1'b0, {own_addr(), i2csp_pkg::DIR_WRITE});
        check("select ack", {7'h00, nack}, 8'h00);
        check("busy", {7'h00, busy}, 8'h01);
        xfer(1'b0, 1'b0, 1'b0, 1'b0, reg_a);
        check("index ack", {7'h00, nack}, 8'h00);
        ptr_m = reg_a;
        for (int i = 0; i < len; i++) begin
            d = 8'($random(seed));
            xfer(1'b0, i == len - 1, 1'b0, 1'b0, d);
            check("data ack", {7'h00, nack}, 8'h00);
            mem_m[ptr_m] = d;
            ptr_m++;
        end
        wait_idle();
        check("pointer", last_addr, ptr_m);
    endtask

    // Random form sets the index and restarts without a STOP in between
    task automatic rd(input logic rnd, input logic [7:0] reg_a, input int len);
        if (rnd) begin
            xfer(1'b1, 1'b0, 1'b0, 1'b0, {own_addr(), i2csp_pkg::DIR_WRITE});
            xfer(1'b0, 1'b0, 1'b0, 1'b0, reg_a);
            check("index ack", {7'h00, nack}, 8'h00);
            ptr_m = reg_a;
        end
        xfer(1'b1, 1'b0, 1'b0, 1'b0, {own_addr(), i2csp_pkg::DIR_READ});
        check("read select ack", {7'h00, nack}, 8'h00);
        for (int i = 0; i < len; i++) begin
            xfer(1'b0, i == len - 1, 1'b1, i != len - 1, 8'h00);
            check("read data", got, mem_m[ptr_m]);
            ptr_m++;
        end
        wait_idle();
        check("pointer", last_addr, ptr_m);
    endtask

    task automatic foreign(input logic [6:0] a);
        xfer(1'b1, 1'b0, 1'b0, 1'b0, {a, i2csp_pkg::DIR_WRITE});
        check("foreign ack", {7'h00, nack}, 8'h01);
        check("foreign busy", {7'h00, busy}, 8'h00);
        xfer(1'b0, 1'b1, 1'b0, 1'b0, 8'hA5);
        check("ignored byte", {7'h00, nack}, 8'h01);
        wait_idle();
        check("pointer kept", last_addr, ptr_m);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Worst case run is about 91k clocks of link traffic
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        end_of_test();
    end

    initial begin
        logic [7:0] a;
        int         len;
        seed = 11784;
        n_fail = 0;
        samples_checked = 0;
        {rst, addr_select_pin, cmd_valid, cmd_start, cmd_stop} = 5'h10;
        {cmd_read, cmd_ack, cmd_data} = 10'h000;
        foreach (mem_m[i]) mem_m[i] = i2csp_pkg::MEM_RESET;
        ptr_m = i2csp_pkg::PTR_RESET;
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        check("pointer reset", last_addr, i2csp_pkg::PTR_RESET);
        rd(1'b0, 8'h00, 1);
        wr(8'hFE, 3);
        rd(1'b0, 8'h00, 1);
        rd(1'b1, 8'hFE, 3);
        foreign(own_addr() ^ 7'h02);
        addr_select_pin = 1'b1;
        foreign(own_addr() ^ 7'h02);
        for (int k = 0; k < 3; k++) begin
            addr_select_pin = 1'($random(seed));
            a = 8'($random(seed));
            len = 1 + ($random(seed) & 1);
            wr(a, len);
            rd(1'b1, a, len);
        end
        end_of_test();
    end
endmodule // tb_i2c_slave_register_port
`default_nettype wire
